// file: rtl/smc_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
`define SMC_OFS_MODE        4'h0
`define SMC_OFS_WAKE        4'h4
`define SMC_OFS_STAT        4'h8
`define SMC_OFS_IMASK       4'hC
`define SMC_TH_LSB          0
`define SMC_TH_W            4
`define SMC_SMPL_LSB        8
`define SMC_SMPL_W          3
`define SMC_RSTEN_BIT       12
`define SMC_IEN_BIT         13
`define SMC_WAKEEN_BIT      1
`define SMC_ST_LIVE_BIT     0
`define SMC_ST_STICKY_BIT   1
`define SMC_TH_MAX          4'hF
`define SMC_MODE_RST        32'h00000000
`define SMC_PER_32          12'h01F
`define SMC_PER_256         12'h0FF
`define SMC_PER_2048        12'h7FF
`define SMC_PER_W           12
`endif

// file: rtl/smc_pkg.sv
// Types shared by the supply monitor control block
package smc_pkg;
  typedef enum logic [2:0] {
    SMC_SMPL_OFF,
    SMC_SMPL_CONT,
    SMC_SMPL_32,
    SMC_SMPL_256,
    SMC_SMPL_2048
  } smc_smpl_t;
  typedef struct packed {
    logic       irq_enable;
    logic       reset_enable;
    logic [2:0] sampling_sel;
    logic [3:0] threshold_sel;
  } smc_mode_t;
  typedef struct packed {
    logic detect_sticky;
    logic live_output;
  } smc_stat_t;
endpackage

// file: rtl/smc_sample_sched.sv
// Sampling scheduler: one-period enable every N slow-clock periods
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module smc_sample_sched
  import smc_pkg::*;
#(
  parameter int W = `SMC_PER_W
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  input  wire logic       i_slck_tick,
  input  wire logic [2:0] i_sel,
  output logic            o_mon_en,
  output logic            o_meas_done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] per;
  logic         cont;
  logic         off;
  // Period terminal count from selection
  always_comb begin
    per  = '0;
    cont = 1'b0;
    off  = 1'b0;
    case (smc_smpl_t'(i_sel))
      SMC_SMPL_CONT: cont = 1'b1;
      SMC_SMPL_32:   per = `SMC_PER_32;
      SMC_SMPL_256:  per = `SMC_PER_256;
      SMC_SMPL_2048: per = `SMC_PER_2048;
      default:       off = 1'b1;
    endcase
  end
  // Slow-clock period counter
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
    end else if (i_ce && i_slck_tick) begin
      if (cont || off || cnt_q >= per) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
  // Enable one period: continuous or at count zero
  assign o_mon_en    = !off && (cont || cnt_q == '0);
  assign o_meas_done = o_mon_en && i_slck_tick && i_ce;
  a_sched_period: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && i_slck_tick && o_mon_en && !cont && !off)
      |=> !o_mon_en || $changed(i_sel))
    else $error("monitor enabled two periods in a row");
endmodule
`default_nettype wire

// file: rtl/smc_sticky.sv
// Sticky event flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module smc_sticky (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_flag
);
  // Set has priority over clear
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_flag <= 1'b0;
    end else if (i_ce) begin
      if (i_set) begin
        o_flag <= 1'b1;
      end else if (i_clr) begin
        o_flag <= 1'b0;
      end
    end
  end
  a_sticky_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && i_set) |=> o_flag)
    else $error("sticky flag not set by event");
endmodule
`default_nettype wire

// file: rtl/smc_top.sv
// Supply monitor control: config, sampling, reset, wakeup, status, irq
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module smc_top
  import smc_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic        i_slck_tick,
  input  wire logic        i_cmp_below,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_avs_readdatavalid,
  output logic [3:0]       o_threshold_sel,
  output logic             o_mon_en,
  output logic             o_core_nreset,
  output logic             o_wakeup,
  output logic             o_irq
);
  ////////////////////////////////////////////////////////////////////
  smc_mode_t  mode_q;
  logic       wake_en_q;
  logic       live_q;
  logic       sticky;
  logic       irq_mask_q;
  logic       ack_q;
  logic       meas_done;
  logic       detect;
  logic       rd_stat;
  logic       wr_sel;
  logic       rd_sel;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic       nreset_q;
  logic       wakeup_q;
  ////////////////////////////////////////////////////////////////////
  // Bus: one wait cycle then answer; a write lands when waitrequest is low
  assign wr_sel = i_avs_write && ack_q;
  assign rd_sel = i_avs_read && !ack_q;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
    end
  end
  // Mode register write, byte enables honoured
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_q <= smc_mode_t'(9'(`SMC_MODE_RST));
    end else if (i_ce && wr_sel && i_avs_address == `SMC_OFS_MODE) begin
      if (i_avs_byteenable[0]) begin
        mode_q.threshold_sel <= i_avs_writedata[`SMC_TH_LSB +: `SMC_TH_W];
      end
      if (i_avs_byteenable[1]) begin
        mode_q.sampling_sel <=
          i_avs_writedata[`SMC_SMPL_LSB +: `SMC_SMPL_W];
        mode_q.reset_enable <= i_avs_writedata[`SMC_RSTEN_BIT];
        mode_q.irq_enable   <= i_avs_writedata[`SMC_IEN_BIT];
      end
    end
  end
  // Wakeup config and interrupt mask
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wake_en_q  <= 1'b0;
      irq_mask_q <= 1'b0;
    end else if (i_ce && wr_sel && i_avs_byteenable[0]) begin
      if (i_avs_address == `SMC_OFS_WAKE) begin
        wake_en_q <= i_avs_writedata[`SMC_WAKEEN_BIT];
      end else if (i_avs_address == `SMC_OFS_IMASK) begin
        irq_mask_q <= i_avs_writedata[`SMC_ST_STICKY_BIT];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Sampling schedule
  smc_sample_sched #(
    .W (`SMC_PER_W)
  ) u_sched (
    .i_mclk      (i_mclk),
    .i_rstn      (i_rstn),
    .i_ce        (i_ce),
    .i_slck_tick (i_slck_tick),
    .i_sel       (mode_q.sampling_sel),
    .o_mon_en    (o_mon_en),
    .o_meas_done (meas_done)
  );
  assign o_threshold_sel = mode_q.threshold_sel;
  // Comparator taken at end of each enabled slow period
  assign detect = meas_done && i_cmp_below;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      live_q <= 1'b0;
    end else if (i_ce && meas_done) begin
      live_q <= i_cmp_below;
    end
  end
  // Sticky flag cleared by status read, set wins
  assign rd_stat = rd_sel && i_avs_address == `SMC_OFS_STAT;
  smc_sticky u_sticky (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_set  (detect),
    .i_clr  (rd_stat),
    .o_flag (sticky)
  );
  // Reset and wakeup pulses, registered
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      nreset_q <= 1'b1;
      wakeup_q <= 1'b0;
    end else if (i_ce) begin
      nreset_q <= !(detect && mode_q.reset_enable);
      wakeup_q <= detect && wake_en_q;
    end
  end
  assign o_core_nreset = nreset_q;
  assign o_wakeup      = wakeup_q;
  // Interrupt level
  assign o_irq = sticky && mode_q.irq_enable && irq_mask_q;
  ////////////////////////////////////////////////////////////////////
  // Read mux, captured before the clear takes effect
  always_comb begin
    rdata_d = 32'h00000000;
    if (i_avs_address == `SMC_OFS_MODE) begin
      rdata_d[`SMC_TH_LSB +: `SMC_TH_W]     = mode_q.threshold_sel;
      rdata_d[`SMC_SMPL_LSB +: `SMC_SMPL_W] = mode_q.sampling_sel;
      rdata_d[`SMC_RSTEN_BIT]               = mode_q.reset_enable;
      rdata_d[`SMC_IEN_BIT]                 = mode_q.irq_enable;
    end else if (i_avs_address == `SMC_OFS_WAKE) begin
      rdata_d[`SMC_WAKEEN_BIT] = wake_en_q;
    end else if (i_avs_address == `SMC_OFS_STAT) begin
      rdata_d[`SMC_ST_LIVE_BIT]   = live_q;
      rdata_d[`SMC_ST_STICKY_BIT] = sticky;
    end else if (i_avs_address == `SMC_OFS_IMASK) begin
      rdata_d[`SMC_ST_STICKY_BIT] = irq_mask_q;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 32'h00000000;
    end else if (i_ce && rd_sel) begin
      rdata_q <= rdata_d;
    end
  end
  assign o_avs_readdata      = rdata_q;
  assign o_avs_readdatavalid = ack_q && i_avs_read;
  ////////////////////////////////////////////////////////////////////
  a_reset_on_detect: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && detect && mode_q.reset_enable) |=> !o_core_nreset)
    else $error("core reset not asserted on detection");
  a_no_spurious_rst: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && !(detect && mode_q.reset_enable)) |=> o_core_nreset)
    else $error("core reset asserted without cause");
  a_wakeup_detect: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && detect && wake_en_q) |=> o_wakeup)
    else $error("wakeup missing on detection");
  a_live_refresh: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && meas_done) |=> live_q == $past(i_cmp_below))
    else $error("live status not refreshed");
  a_sticky_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && rd_stat && !detect) |=> !sticky)
    else $error("status read did not clear sticky bit");
  a_sticky_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && sticky && !detect && !rd_stat) |=> sticky)
    else $error("sticky bit lost without a status read");
  a_live_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && !meas_done) |=> $stable(live_q))
    else $error("live status changed between measurements");
  a_wake_quiet: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && !(detect && wake_en_q)) |=> !o_wakeup)
    else $error("wakeup raised without cause");
  a_mon_off: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (mode_q.sampling_sel == 3'h0) |-> !o_mon_en)
    else $error("monitor enabled while sampling is off");
  // Bus answers after exactly one wait cycle
  a_wait_one: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && (i_avs_read || i_avs_write) && o_avs_waitrequest)
      |=> !o_avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  a_rdvalid_read: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_avs_readdatavalid |-> (i_avs_read && !o_avs_waitrequest))
    else $error("read data valid outside a read answer");
  // Clock enable low freezes all state
  a_ce_freeze: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_ce |=> ($stable(mode_q) && $stable(sticky) && $stable(live_q)
      && $stable(o_core_nreset) && $stable(o_wakeup)))
    else $error("state moved while clock enable low");
  a_irq_level: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_irq == (sticky && mode_q.irq_enable && irq_mask_q))
    else $error("interrupt level wrong");
  a_cont_enable: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (mode_q.sampling_sel == 3'h1) |-> o_mon_en)
    else $error("continuous mode not enabled");
  a_thresh_out: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && wr_sel && i_avs_address == `SMC_OFS_MODE && i_avs_byteenable[0])
      |=> o_threshold_sel == $past(i_avs_writedata[3:0]))
    else $error("threshold not applied");
endmodule
`default_nettype wire

// file: tb/smc_cmp_model.sv
// Behavioural comparator on the main I/O supply
`timescale 1ns/1ps
`default_nettype none
module smc_cmp_model (
  input  wire logic        i_mclk,
  input  wire logic        i_mon_en,
  input  wire logic [3:0]  i_threshold_sel,
  input  wire logic [15:0] i_supply_mv,
  output logic             o_below
);
  logic [15:0] lvl;
  logic        tgl = 1'b0;
  // Trip level: 1.9V plus 100 mV per code
  assign lvl = 16'h076C + 16'h0064 * {12'h000, i_threshold_sel};
  // Unpowered output wanders, so it is never mistaken for a result
  always @(posedge i_mclk) tgl <= ~tgl;
  assign o_below = i_mon_en ? (i_supply_mv < lvl) : tgl;
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module tb;
  logic        i_mclk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_slck_tick = 1'b0;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [3:0]  i_avs_address = 4'h0;
  logic [3:0]  i_avs_byteenable = 4'hF;
  logic [31:0] i_avs_writedata = 32'h0;
  logic        i_cmp_below, o_avs_waitrequest, o_avs_readdatavalid;
  logic        o_mon_en, o_core_nreset, o_wakeup, o_irq;
  logic [3:0]  o_threshold_sel;
  logic [31:0] o_avs_readdata, q;
  logic [15:0] supply = 16'h0BB8;
  logic [1:0]  div = 2'h0;
  logic [6:0]  rows [4] = '{7'h5D, 7'h32, 7'h08, 7'h7F};
  logic [2:0]  codes [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  int          per [4] = '{1, 32, 256, 2048};
  int fails = 0, comparisons = 0, cyc = 0, n_rst = 0, n_wake = 0;
  int ticks = 0, last = 0, gap = 0, en_seen = 0, e0;

  smc_top i_dut (.i_mclk, .i_rstn, .i_ce, .i_slck_tick, .i_cmp_below,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .o_avs_readdatavalid, .o_threshold_sel, .o_mon_en, .o_core_nreset,
    .o_wakeup, .o_irq);
  smc_cmp_model i_cmp (.i_mclk, .i_mon_en(o_mon_en),
    .i_threshold_sel(o_threshold_sel), .i_supply_mv(supply),
    .o_below(i_cmp_below));

  ////////////////////////////////////////////////////////////////////////
  // Clock
  always #20 i_mclk = ~i_mclk;
  // Slow tick every 4 cycles, pulse counters, enable spacing
  always @(posedge i_mclk) begin
    div <= div + 2'h1;
    i_slck_tick <= (div == 2'h3);
    cyc <= cyc + 1;
    if (o_core_nreset === 1'b0) n_rst <= n_rst + 1;
    if (o_wakeup === 1'b1) n_wake <= n_wake + 1;
    if (i_slck_tick === 1'b1) begin
      ticks <= ticks + 1;
      if (o_mon_en === 1'b1) begin
        gap <= ticks - last;
        last <= ticks;
        en_seen <= en_seen + 1;
      end
    end
  end
  // Hang guard
  always @(posedge i_mclk) if (cyc == 60000) begin
    fails++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One Avalon access; read data land in q
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge i_mclk);
    i_avs_read <= ~w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_mclk);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    // Let the answering edge settle before callers look at outputs
    @(negedge i_mclk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, `SMC_OFS_MODE, {18'h0, rows[i][4], rows[i][6], 4'h1, 8'h05});
      bus(1'b1, `SMC_OFS_WAKE, {30'h0, rows[i][5], 1'b0});
      bus(1'b1, `SMC_OFS_IMASK, {30'h0, rows[i][3], 1'b0});
      bus(1'b0, `SMC_OFS_STAT, 32'h0);
      n_rst = 0;
      n_wake = 0;
      supply <= 16'h07D0;
      repeat (16) @(posedge i_mclk);
      supply <= 16'h0BB8;
      repeat (12) @(posedge i_mclk);
      chk(n_rst > 0, rows[i][2]);
      chk(n_wake > 0, rows[i][1]);
      chk(o_irq, rows[i][0]);
      rdc(`SMC_OFS_STAT, 32'h2);
      chk(o_irq, 32'h0);
      $display("detect row %0d done", i);
    end
    bus(1'b1, `SMC_OFS_MODE, 32'h0000000F);
    chk(o_threshold_sel, 32'hF);
    rdc(`SMC_OFS_MODE, 32'hF);
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    rdc(4'h2, 32'h0);
    repeat (2) @(posedge i_mclk);
    e0 = en_seen;
    repeat (200) @(posedge i_mclk);
    chk(en_seen - e0, 32'h0);
    $display("threshold and off test done");
    foreach (codes[i]) begin
      bus(1'b1, `SMC_OFS_MODE, {21'h0, codes[i], 8'h00});
      e0 = en_seen;
      while (en_seen < e0 + 3) @(posedge i_mclk);
      chk(gap, per[i]);
    end
    $display("sampling test done");
    bus(1'b1, `SMC_OFS_MODE, 32'h00000200);
    e0 = en_seen;
    while (en_seen < e0 + 2) @(posedge i_mclk);
    supply <= 16'h0708;
    rdc(`SMC_OFS_STAT, 32'h0);
    e0 = en_seen;
    while (en_seen < e0 + 2) @(posedge i_mclk);
    rdc(`SMC_OFS_STAT, 32'h3);
    $display("live refresh test done");
    // Mid-run reset while detections fire
    supply <= 16'h07D0;
    bus(1'b1, `SMC_OFS_MODE, 32'h000031FF);
    repeat (8) @(posedge i_mclk);
    i_rstn <= 1'b0;
    @(negedge i_mclk);
    chk(o_core_nreset, 32'h1);
    chk(o_wakeup, 32'h0);
    chk(o_irq, 32'h0);
    chk(o_threshold_sel, 32'h0);
    chk(o_mon_en, 32'h0);
    chk(o_avs_readdata, 32'h0);
    @(posedge i_mclk);
    i_rstn <= 1'b1;
    supply <= 16'h0BB8;
    rdc(`SMC_OFS_MODE, 32'h0);
    rdc(`SMC_OFS_STAT, 32'h0);
    $display("reset test done");
    // Clock enable low: no detection taken while frozen
    bus(1'b1, `SMC_OFS_MODE, 32'h00001105);
    rdc(`SMC_OFS_STAT, 32'h0);
    @(posedge i_mclk);
    i_ce <= 1'b0;
    supply <= 16'h07D0;
    n_rst = 0;
    repeat (20) @(posedge i_mclk);
    supply <= 16'h0BB8;
    @(posedge i_mclk);
    i_ce <= 1'b1;
    repeat (20) @(posedge i_mclk);
    chk(n_rst, 32'h0);
    rdc(`SMC_OFS_STAT, 32'h0);
    $display("clock enable test done");
    wrap_up();
  end
endmodule
`default_nettype wire
